/* logic/wdhm_top.v */
`timescale 1ns/1ps
`include "wdhm_defines.vh"
module wdhm_top (
   input wire clk,
   input wire resetn,
   input wire [3:0] bus_addr,
   input wire bus_wr,
   input wire bus_rd,
   input wire [7:0] bus_wdata,
   output reg [7:0] bus_rdata,
   input wire iso_in_one,
   input wire iso_in_two,
   input wire pushbutton_reset_n,
   input wire sys_reset_pulse,
   input wire over_temp,
   input wire over_volt,
   input wire under_volt,
   input wire fan_current,
   input wire [7:0] temp_adc,
   input wire [7:0] light_adc,
   output reg timeout_reset_out,
   output reg timeout_reset_out_n,
   output reg irq,
   output reg isolated_output_one,
   output reg isolated_output_two,
   output reg plain_output_one,
   output reg plain_output_two,
   output reg fan_pwm
);
   // ***************************************************
   // Reset release and input synchronisers
   // ***************************************************
   reg rst_meta_q;
   reg rst_n_q;
   reg [23:0] sync1_q;
   reg [23:0] sync2_q;
   reg sysrst_prev_q;
   wire [23:0] raw_in;
   // Reset asserts at once, releases two edges later
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rst_meta_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n_q <= rst_meta_q;
      end
   end
   assign raw_in = {pushbutton_reset_n, iso_in_one, iso_in_two,
                    sys_reset_pulse, over_temp, over_volt, under_volt,
                    fan_current, temp_adc, light_adc};
   // Pins are asynchronous; first stage read only by second
   always @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         sync1_q <= `WDHM_SYNC_RST;
         sync2_q <= `WDHM_SYNC_RST;
         sysrst_prev_q <= 1'b0;
      end else begin
         sync1_q <= raw_in;
         sync2_q <= sync1_q;
         sysrst_prev_q <= sync2_q[20];
      end
   end
   wire pb_n_s = sync2_q[23];
   wire iso1_s = sync2_q[22];
   wire iso2_s = sync2_q[21];
   wire sysrst_rise = sync2_q[20] & ~sysrst_prev_q;
   wire ot_s = sync2_q[19];
   wire ov_s = sync2_q[18];
   wire uv_s = sync2_q[17];
   wire fan_i_s = sync2_q[16];
   wire [7:0] temp_s = sync2_q[15:8];
   wire [7:0] light_s = sync2_q[7:0];
   // ***************************************************
   // Bus clock ticks derived from the system clock
   // ***************************************************
   reg [16:0] acc_q;
   reg [3:0] div_q;
   reg half_q;
   wire [17:0] acc_sum = {1'b0, acc_q} + `WDHM_BUS_KHZ;
   wire bus_tick = (acc_sum >= `WDHM_SYS_KHZ);
   wire tick0 = bus_tick & (div_q == `WDHM_C0_DIV);
   // Fractional accumulator keeps average rate exact
   always @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         acc_q <= 17'h00000;
         div_q <= 4'h0;
         half_q <= 1'b0;
      end else begin
         if (bus_tick) begin
            acc_q <= acc_sum[16:0] - `WDHM_SYS_KHZ;
            div_q <= div_q + 4'h1;
            half_q <= ~half_q;
         end else begin
            acc_q <= acc_sum[16:0];
         end
      end
   end
   // ***************************************************
   // Register writes, counters and reset control
   // ***************************************************
   reg [15:0] load_q [0:2];
   reg [15:0] cnt_q [0:2];
   reg [7:0] lsb_q [0:2];
   reg [2:0] wptr_q;
   reg [2:0] rptr_q;
   reg [7:0] opt_q;
   reg [7:0] irqen_q;
   reg [1:0] outs_q;
   reg slow_q;
   reg expired_q;
   reg remind_q;
   reg active_q;
   reg irq_q;
   reg [7:0] pwm_cnt_q;
   integer i;
   wire armed = opt_q[`WDHM_OPT_ARM];
   wire wr_cnt = bus_wr & (bus_addr <= `WDHM_OFS_CNT2);
   wire c0_pulse = armed & tick0 & (cnt_q[0] == 16'h0001);
   wire tick2 = slow_q ? tick0 : (bus_tick & half_q);
   wire fan_fault = ~fan_i_s | (temp_s == 8'hff);
   wire [7:0] status = {irq_q, uv_s, ov_s, fan_fault,
                        iso2_s | active_q, iso1_s, ot_s,
                        remind_q};
   wire reload1 = wr_cnt & (bus_addr == `WDHM_OFS_CNT1) & wptr_q[1];
   wire expire = c0_pulse & ~expired_q & (cnt_q[1] == 16'h0001);
   wire warn = c0_pulse & ~expired_q & (cnt_q[1] == 16'h0002);
   wire irq_evt = (warn & irqen_q[`WDHM_ST_REMIND])
                | (ot_s & irqen_q[`WDHM_ST_TEMP])
                | (iso1_s & irqen_q[`WDHM_ST_ISO1])
                | (fan_fault & irqen_q[`WDHM_ST_FAN])
                | ((ov_s | uv_s) & irqen_q[`WDHM_ST_OV]);
   // Counter bytes arrive low then high; load on high byte
   always @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         for (i = 0; i < 3; i = i + 1) begin
            load_q[i] <= 16'h0000;
            cnt_q[i] <= 16'h0000;
            lsb_q[i] <= 8'h00;
         end
         wptr_q <= 3'h0;
         opt_q <= `WDHM_OPT_RST;
         irqen_q <= `WDHM_IRQEN_RST;
         outs_q <= 2'h0;
         slow_q <= 1'b0;
         expired_q <= 1'b0;
         remind_q <= 1'b0;
         active_q <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         for (i = 0; i < 3; i = i + 1) begin
            if (wr_cnt && bus_addr == i[3:0]) begin
               if (!wptr_q[i]) begin
                  lsb_q[i] <= bus_wdata;
               end else begin
                  load_q[i] <= {bus_wdata, lsb_q[i]};
               end
               wptr_q[i] <= ~wptr_q[i];
            end
         end
         // Counter 0 divides the tick; zero load means 65536
         if (wr_cnt && bus_addr == `WDHM_OFS_CNT0 && wptr_q[0]) begin
            cnt_q[0] <= {bus_wdata, lsb_q[0]};
         end else if (armed && tick0) begin
            if (cnt_q[0] == 16'h0001) begin
               cnt_q[0] <= load_q[0];
            end else begin
               cnt_q[0] <= cnt_q[0] - 16'h0001;
            end
         end
         // Counter 1 steps once per counter 0 period
         if (reload1) begin
            cnt_q[1] <= {bus_wdata, lsb_q[1]};
            expired_q <= 1'b0;
            remind_q <= 1'b0;
         end else if (c0_pulse && !expired_q) begin
            cnt_q[1] <= cnt_q[1] - 16'h0001;
            if (expire) begin
               expired_q <= 1'b1;
            end
            if (warn) begin
               remind_q <= 1'b1;
            end
         end
         // Reset pulse width comes from counter 2
         if (expire && opt_q[`WDHM_OPT_RSTEN]) begin
            active_q <= 1'b1;
            cnt_q[2] <= load_q[2];
         end else if (active_q) begin
            if (sysrst_rise) begin
               active_q <= 1'b0;
            end else if (tick2) begin
               if (cnt_q[2] == 16'h0001) begin
                  active_q <= 1'b0;
               end else begin
                  cnt_q[2] <= cnt_q[2] - 16'h0001;
               end
            end
         end
         // Rate select: write sets slow, read restores
         if (bus_wr && bus_addr == `WDHM_OFS_C2RATE) begin
            slow_q <= 1'b1;
         end else if (bus_rd && bus_addr == `WDHM_OFS_C2RATE) begin
            slow_q <= 1'b0;
         end
         if (bus_wr && bus_addr == `WDHM_OFS_OPTIONS) begin
            opt_q <= bus_wdata;
         end
         if (bus_wr && bus_addr == `WDHM_OFS_STATUS) begin
            irqen_q <= bus_wdata;
         end
         if (bus_wr && bus_addr == `WDHM_OFS_OUTPUTS) begin
            outs_q <= bus_wdata[1:0];
         end
         // A new event wins over a clear in the same cycle
         if (irq_evt) begin
            irq_q <= 1'b1;
         end else if (bus_wr && bus_addr == `WDHM_OFS_IRQCLR) begin
            irq_q <= 1'b0;
         end
      end
   end
   // ***************************************************
   // Read data, outputs and fan drive
   // ***************************************************
   reg [7:0] rsel;
   reg [1:0] ridx;
   always @* begin
      ridx = bus_addr[1:0];
      rsel = 8'h00;
      case (bus_addr)
         `WDHM_OFS_CNT0, `WDHM_OFS_CNT1, `WDHM_OFS_CNT2: begin
            rsel = rptr_q[ridx] ? cnt_q[ridx][15:8] : cnt_q[ridx][7:0];
         end
         `WDHM_OFS_STATUS, `WDHM_OFS_IMAGE: rsel = status;
         `WDHM_OFS_TEMP: rsel = temp_s;
         `WDHM_OFS_LIGHT: rsel = light_s;
         `WDHM_OFS_OPTIONS: rsel = opt_q;
         `WDHM_OFS_OUTPUTS: rsel = {6'h00, outs_q};
         default: rsel = 8'h00;
      endcase
   end
   // Read data registered one edge after the strobe
   always @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         bus_rdata <= 8'h00;
         rptr_q <= 3'h0;
         pwm_cnt_q <= 8'h00;
         timeout_reset_out <= 1'b0;
         timeout_reset_out_n <= 1'b1;
         irq <= 1'b0;
         isolated_output_one <= 1'b0;
         isolated_output_two <= 1'b0;
         plain_output_one <= 1'b0;
         plain_output_two <= 1'b0;
         fan_pwm <= 1'b0;
      end else begin
         if (bus_rd) begin
            bus_rdata <= rsel;
            if (bus_addr <= `WDHM_OFS_CNT2) begin
               rptr_q[ridx] <= ~rptr_q[ridx];
            end
         end
         // Any of three reset sources drives both polarities
         timeout_reset_out <= active_q | ~pb_n_s
            | (iso2_s & opt_q[`WDHM_OPT_ISO2EN]);
         timeout_reset_out_n <= ~(active_q | ~pb_n_s
            | (iso2_s & opt_q[`WDHM_OPT_ISO2EN]));
         irq <= irq_q;
         isolated_output_one <= outs_q[0];
         isolated_output_two <= outs_q[1];
         plain_output_one <= outs_q[0];
         plain_output_two <= outs_q[1];
         if (bus_tick) begin
            pwm_cnt_q <= (pwm_cnt_q == 8'hfe) ? 8'h00 : pwm_cnt_q + 8'h01;
         end
         // Duty tracks temperature; full scale is always on
         fan_pwm <= (pwm_cnt_q < temp_s);
      end
   end
endmodule

/* logic/wdhm_defines.vh */
// Functional notes
// - Three 16-bit down-counters, loaded above one
// - Counters 0 and 1 count only when armed; software reloads periodically
// - Counter 1 expired drives resets
// - Expiry asserts resets only when reset enabled
// - Reset holds until bus pulse, power, counter 2
// - Counter 0 ticks at bus clock over 16
// - Counter 0 clocks counter 1; divide 2..65536
// - Counter 2 times reset; default half bus clock
// - Write +C selects slow rate; read restores
// - Warning interrupt one counter-0 period before timeout
// - Five volt over/under flags with optional interrupt
// - Twelve volt rails share over/under flags
// - Over-temperature at status bit 1, optional interrupt
// - Temperature converter result readable by software
// - Light level converter result readable by software
// - Both isolated inputs in status; input 1 interrupt
// - Two isolated outputs, mirrored on plain outputs
// - Input 2 reset ORed with pushbutton and timeout
// - Fan PWM duty rises with temperature
// - Fan fault on no current or full duty
// - Status byte layout bit 0 to bit 7
`ifndef WDHM_DEFINES_VH
`define WDHM_DEFINES_VH
// ***************************************************
// Register offsets
// ***************************************************
`define WDHM_OFS_CNT0 4'h0
`define WDHM_OFS_CNT1 4'h1
`define WDHM_OFS_CNT2 4'h2
`define WDHM_OFS_STATUS 4'h4
`define WDHM_OFS_TEMP 4'h5
`define WDHM_OFS_LIGHT 4'h6
`define WDHM_OFS_OPTIONS 4'h7
`define WDHM_OFS_IMAGE 4'h8
`define WDHM_OFS_IRQCLR 4'h9
`define WDHM_OFS_C2RATE 4'hc
`define WDHM_OFS_OUTPUTS 4'hd
// ***************************************************
// Field positions
// ***************************************************
`define WDHM_OPT_ARM 0
`define WDHM_OPT_RSTEN 1
`define WDHM_OPT_ISO2EN 2
`define WDHM_ST_REMIND 0
`define WDHM_ST_TEMP 1
`define WDHM_ST_ISO1 2
`define WDHM_ST_ISO2 3
`define WDHM_ST_FAN 4
`define WDHM_ST_OV 5
`define WDHM_ST_UV 6
`define WDHM_ST_IRQ 7
// ***************************************************
// Reset values and timing
// ***************************************************
`define WDHM_OPT_RST 8'h00
`define WDHM_IRQEN_RST 8'h00
`define WDHM_SYNC_RST 24'h800000
`define WDHM_SYS_KHZ 17'h1e848
`define WDHM_BUS_KHZ 18'h08235
`define WDHM_ACC_W 17
`define WDHM_C0_DIV 4'hf
`endif

/* verif/wdhm_props.sv */
`timescale 1ns/1ps
// ******************************
// Port checker for the watchdog
// ******************************
module wdhm_props (
   input wire clk,
   input wire resetn,
   input wire [3:0] bus_addr,
   input wire bus_wr,
   input wire bus_rd,
   input wire [7:0] bus_wdata,
   input wire [7:0] bus_rdata,
   input wire sys_reset_pulse,
   input wire pushbutton_reset_n,
   input wire [7:0] temp_adc,
   input wire timeout_reset_out,
   input wire timeout_reset_out_n,
   input wire irq,
   input wire isolated_output_one,
   input wire isolated_output_two,
   input wire plain_output_one,
   input wire plain_output_two,
   input wire fan_pwm
);
   reg rsten_q;
   reg iso2en_q;
   reg irqen_q;
   reg [3:0] age_q;
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   // Shadow of the enables, rebuilt from bus writes alone
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rsten_q <= 1'b0;
         iso2en_q <= 1'b0;
         irqen_q <= 1'b0;
      end else if (bus_wr && bus_addr == 4'h7) begin
         rsten_q <= bus_wdata[1];
         iso2en_q <= bus_wdata[2];
      end else if (bus_wr && bus_addr == 4'h4) begin
         irqen_q <= |(bus_wdata & 8'h37);
      end
   end
   // Settled converter input; covers the two-stage synchroniser
   always @(posedge clk or negedge resetn) begin
      if (!resetn)
         age_q <= 4'h0;
      else if ($changed(temp_adc))
         age_q <= 4'h0;
      else if (age_q != 4'hf)
         age_q <= age_q + 4'h1;
   end
   a_reset_pair_compl:
      assert property (timeout_reset_out_n != timeout_reset_out)
      else $error("reset outputs not complementary");
   a_plain_one_mirror:
      assert property (plain_output_one == isolated_output_one)
      else $error("plain output one differs");
   a_plain_two_mirror:
      assert property (plain_output_two == isolated_output_two)
      else $error("plain output two differs");
   // Pushbutton is always a source; its pin leads the output by 3
   a_reset_needs_enable:
      assert property ($rose(timeout_reset_out) |-> rsten_q || iso2en_q
         || !$past(pushbutton_reset_n, 3))
      else $error("reset raised while disabled");
   a_bus_pulse_release:
      assert property ($rose(sys_reset_pulse) && timeout_reset_out &&
         !iso2en_q |-> ##[1:8] !timeout_reset_out)
      else $error("reset not released by bus pulse");
   a_unmapped_reads_zero:
      assert property (bus_rd && (bus_addr == 4'h3 || bus_addr == 4'hf)
         |=> bus_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_temp_read_value:
      assert property (bus_rd && bus_addr == 4'h5 && age_q == 4'hf
         |=> bus_rdata == $past(temp_adc))
      else $error("temperature read wrong");
   a_irq_needs_source:
      assert property ($rose(irq) |-> irqen_q)
      else $error("irq without enabled source");
   a_pwm_off_cold:
      assert property (age_q == 4'hf && temp_adc == 8'h00 |-> !fan_pwm)
      else $error("fan driven at zero temperature");
   c_timeout: cover property ($rose(timeout_reset_out));
   c_irq: cover property ($rose(irq));
   c_release: cover property ($rose(sys_reset_pulse) && timeout_reset_out);
endmodule
bind wdhm_top wdhm_props i_wdhm_props (.clk(clk), .resetn(resetn),
   .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
   .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
   .sys_reset_pulse(sys_reset_pulse), .temp_adc(temp_adc),
   .pushbutton_reset_n(pushbutton_reset_n),
   .timeout_reset_out(timeout_reset_out),
   .timeout_reset_out_n(timeout_reset_out_n), .irq(irq),
   .isolated_output_one(isolated_output_one),
   .isolated_output_two(isolated_output_two),
   .plain_output_one(plain_output_one),
   .plain_output_two(plain_output_two), .fan_pwm(fan_pwm));

/* verif/wdhm_sys_model.sv */
`timescale 1ns/1ps
// *************************************
// Host side: returns a bus reset pulse
// *************************************
module wdhm_sys_model (
   input wire clk,
   input wire en,
   input wire rst_seen,
   output reg sys_pulse = 1'b0
);
   reg [5:0] age_q = 6'h00;
   // Slow host: pulse some 20 cycles into the reset, then low
   always @(posedge clk) begin
      if (!en || !rst_seen) begin
         age_q <= 6'h00;
         sys_pulse <= 1'b0;
      end else begin
         if (age_q != 6'h3f)
            age_q <= age_q + 6'h01;
         sys_pulse <= (age_q[5:2] == 4'h5);
      end
   end
endmodule

/* verif/test_watchdog_health_monitor.sv */
`timescale 1ns/1ps
// ***************************
// Bench for the watchdog top
// ***************************
module test_watchdog_health_monitor;
   reg clk = 1'b0, resetn = 1'b0, bus_wr = 1'b0, bus_rd = 1'b0;
   reg iso_in_one = 1'b1, iso_in_two = 1'b0, over_temp = 1'b1;
   reg over_volt = 1'b1, under_volt = 1'b0, fan_current = 1'b0;
   reg sys_en = 1'b0, pb_n = 1'b1;
   reg [3:0] bus_addr = 4'h0;
   reg [7:0] bus_wdata = 8'h00, temp_adc = 8'h5a, light_adc = 8'ha5, rv;
   wire [7:0] bus_rdata;
   wire sys_pulse, rst_o, rst_on, irq, iso1, iso2, pl1, pl2, pwm;
   integer fail_count = 0, check_count = 0, cyc = 0, n, k;
   // Half period of the 125 MHz clock
   always #4 clk = ~clk;
   wdhm_top i_wdhm_top (.clk(clk), .resetn(resetn), .bus_addr(bus_addr),
      .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata),
      .bus_rdata(bus_rdata), .iso_in_one(iso_in_one),
      .iso_in_two(iso_in_two), .pushbutton_reset_n(pb_n),
      .sys_reset_pulse(sys_pulse), .over_temp(over_temp),
      .over_volt(over_volt), .under_volt(under_volt),
      .fan_current(fan_current), .temp_adc(temp_adc),
      .light_adc(light_adc), .timeout_reset_out(rst_o),
      .timeout_reset_out_n(rst_on), .irq(irq),
      .isolated_output_one(iso1), .isolated_output_two(iso2),
      .plain_output_one(pl1), .plain_output_two(pl2), .fan_pwm(pwm));
   wdhm_sys_model i_wdhm_sys_model (.clk(clk), .en(sys_en),
      .rst_seen(rst_o), .sys_pulse(sys_pulse));
   task chk(input [95:0] nm, input [15:0] seen, input [15:0] exp);
      check_count = check_count + 1;
      if (seen !== exp) begin
         fail_count = fail_count + 1;
         $display("MISMATCH %0s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task wr(input [3:0] a, input [7:0] d);
      @(posedge clk);
      bus_addr <= a;
      bus_wdata <= d;
      bus_wr <= 1'b1;
      @(posedge clk);
      bus_wr <= 1'b0;
   endtask
   task rd(input [3:0] a);
      @(posedge clk);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge clk);
      bus_rd <= 1'b0;
      #1 rv = bus_rdata;
   endtask
   // Counters take low byte then high byte
   task ld(input [3:0] a, input [15:0] v);
      wr(a, v[7:0]);
      wr(a, v[15:8]);
   endtask
   task arm(input [7:0] opt);
      ld(4'h0, 16'h0002);
      ld(4'h1, 16'h0003);
      wr(4'h7, opt);
   endtask
   // Bounded wait; n holds the cycles spent, running out is a mismatch
   task wait_on(input lvl, input sel);
      n = 0;
      while ((sel ? irq : rst_o) !== lvl && n < 3000) begin
         @(posedge clk);
         #1 n = n + 1;
      end
      chk("wait", n < 3000, 1'b1);
   endtask
   task t_regs;
      rd(4'h4);
      chk("status", rv, 8'h36);
      rd(4'h5);
      chk("temp", rv, 8'h5a);
      rd(4'h6);
      chk("light", rv, 8'ha5);
      rd(4'hf);
      chk("unmapped", rv, 8'h00);
      iso_in_two <= 1'b1;
      wr(4'h4, 8'h02);
      repeat (4) @(posedge clk);
      rd(4'h4);
      chk("status irq", rv, 8'hbe);
      chk("irq", irq, 1'b1);
      iso_in_two <= 1'b0;
      wr(4'h4, 8'h00);
      wr(4'h9, 8'h00);
      repeat (4) @(posedge clk);
      #1 chk("irq clear", irq, 1'b0);
      $display("register test done");
   endtask
   task t_out;
      for (k = 0; k < 4; k = k + 1) begin
         wr(4'hd, k[7:0]);
         repeat (3) @(posedge clk);
         #1 chk("outputs", {iso2, iso1, pl2, pl1},
            {k[1:0], k[1:0]});
      end
      $display("output test done");
   endtask
   task t_timeout;
      wr(4'h4, 8'h01);
      ld(4'h2, 16'h1000);
      sys_en <= 1'b1;
      arm(8'h03);
      wait_on(1'b1, 1'b1);
      chk("early", rst_o, 1'b0);
      wait_on(1'b1, 1'b0);
      chk("lead", n >= 110 && n <= 130, 1'b1);
      chk("reset pair", {rst_o, rst_on}, 2'b10);
      wait_on(1'b0, 1'b0);
      chk("released", n < 200, 1'b1);
      sys_en <= 1'b0;
      wr(4'h7, 8'h00);
      wr(4'h4, 8'h00);
      wr(4'h9, 8'h00);
      $display("timeout test done");
   endtask
   task t_no_rst;
      ld(4'h2, 16'h000a);
      arm(8'h01);
      repeat (600) @(posedge clk);
      #1 chk("no reset", rst_o, 1'b0);
      rd(4'h4);
      chk("reminder", rv[0], 1'b1);
      wr(4'h7, 8'h00);
      $display("disabled reset test done");
   endtask
   // Hold time at default rate, then after a rate-select write
   task t_hold;
      for (k = 0; k < 2; k = k + 1) begin
         if (k == 0)
            rd(4'hc);
         else
            wr(4'hc, 8'h00);
         ld(4'h2, 16'h000a);
         arm(8'h03);
         wait_on(1'b1, 1'b0);
         wait_on(1'b0, 1'b0);
         wr(4'h7, 8'h00);
         chk("hold", k ? n > 400 : n < 200, 1'b1);
      end
      rd(4'hc);
      $display("hold test done");
   endtask
   task t_fan;
      fan_current <= 1'b1;
      for (k = 0; k < 3; k = k + 1) begin
         temp_adc <= (k == 0) ? 8'h00 : (k == 1) ? 8'h80 : 8'hff;
         repeat (20) @(posedge clk);
         n = 0;
         repeat (1913) begin
            @(posedge clk);
            if (pwm === 1'b1)
               n = n + 1;
         end
         chk("duty", k == 1 ? n > 900 && n < 1020
            : n == k / 2 * 1913, 1'b1);
         rd(4'h4);
         chk("fan fault", rv[4], k == 2);
      end
      $display("fan test done");
   endtask
   // Remote input only with its enable; pushbutton always
   task t_remote;
      wr(4'h7, 8'h04);
      iso_in_two <= 1'b1;
      repeat (5) @(posedge clk);
      #1 chk("remote", rst_o, 1'b1);
      wr(4'h7, 8'h00);
      repeat (5) @(posedge clk);
      #1 chk("no remote", rst_o, 1'b0);
      iso_in_two <= 1'b0;
      pb_n <= 1'b0;
      repeat (5) @(posedge clk);
      #1 chk("button", {rst_o, rst_on}, 2'b10);
      pb_n <= 1'b1;
      repeat (5) @(posedge clk);
      #1 chk("button off", rst_o, 1'b0);
      $display("remote reset test done");
   endtask
   task wrap_up;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // Hang guard, well above the expected run length
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         fail_count = fail_count + 1;
         wrap_up;
      end
   end
   initial begin
      repeat (16) @(posedge clk);
      resetn <= 1'b1;
      repeat (3) @(posedge clk);
      t_regs;
      t_out;
      t_timeout;
      t_no_rst;
      t_hold;
      t_fan;
      t_remote;
      wrap_up;
   end
endmodule
